/* File: flash_port_pkg.sv */
`default_nettype none

package flash_port_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Address layout and array geometry.
  localparam int ADDR_W = 18;
  localparam int SEC_HI = 17;
  localparam int SEC_LO = 12;
  localparam int PG_HI = 11;
  localparam int PG_LO = 7;
  localparam int BLK_HI = 6;
  localparam int BLK_LO = 4;
  localparam int BYTE_HI = 3;
  localparam int AUX_BYTE_HI = 1;
  localparam int BLKS = 9;
  localparam int BLK_BITS = 128;
  localparam int WORD_BITS = 32;
  localparam int BYTE_BITS = 8;
  localparam int BUS_BYTES = 4;
  localparam logic [3:0] AUX_BLK = 4'h8;
  localparam logic [3:0] LAST_BLK = 4'h8;
  localparam logic [5:0] SEC_ZERO = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sizes, completion codes and timing.
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_FIX = 2'h1;
  localparam logic [1:0] ST_MULTI = 2'h2;
  localparam logic [1:0] ST_LOSS = 2'h3;
  localparam int SWAP_CYCLES_DEF = 4;
  localparam logic [3:0] PIPE_EXTRA = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Enumerations.
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_INIT = 4'h1,
    OP_BRST = 4'h2,
    OP_READ = 4'h3,
    OP_WRITE = 4'h4,
    OP_ERASE = 4'h5,
    OP_PROG = 4'h6,
    OP_UNPROT = 4'h7,
    OP_DISC = 4'h8
  } op_e;

  typedef enum logic [1:0] {
    ARR_RD = 2'h0,
    ARR_WR = 2'h1,
    ARR_ERASE = 2'h2,
    ARR_QUERY = 2'h3
  } arr_cmd_e;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_LOAD = 8'h02,
    S_SWAP = 8'h04,
    S_QUERY = 8'h08,
    S_PROG = 8'h10,
    S_ERASE = 8'h20,
    S_READ = 8'h40,
    S_WAIT = 8'h80
  } state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef struct packed {
    logic rd;
    logic wr;
    logic page_clear_request;
    logic prog;
    logic page_unlock_copy;
    logic discard;
  } req_s;

  typedef struct packed {
    logic extra_page_select;
    logic side_block_select;
    logic [1:0] transfer_size;
    logic buffer_hold_guard;
    logic lock_on_program;
    logic pipe;
  } mode_s;

  typedef struct packed {
    logic [5:0] sector;
    logic [4:0] page;
    logic spare;
    logic [3:0] blk;
    logic [3:0] byte_off;
  } loc_s;

  typedef struct packed {
    logic req;
    arr_cmd_e cmd;
    loc_s loc;
    logic [BLK_BITS-1:0] wdata;
    logic lock;
  } arr_req_s;

  typedef struct packed {
    logic ack;
    logic [BLK_BITS-1:0] rdata;
    logic [1:0] ecc;
    logic prot;
    logic thr;
  } arr_rsp_s;

endpackage : flash_port_pkg

`default_nettype wire

/* File: op_priority.sv */
`timescale 1ns/10ps
`default_nettype none

module op_priority (
  // Reset style requests
  input wire logic sys_init,
  input wire logic block_reset_n,
  // User operation requests
  input wire flash_port_pkg::req_s req,
  // Winning operation
  output flash_port_pkg::op_e op
);
  import flash_port_pkg::*;

  // Highest priority first; only one operation is served per accepted cycle.
  always_comb
  begin
    if (sys_init)
      op = OP_INIT;
    else if (!block_reset_n)
      op = OP_BRST;
    else if (req.rd)
      op = OP_READ;
    else if (req.wr)
      op = OP_WRITE;
    else if (req.page_clear_request)
      op = OP_ERASE;
    else if (req.prog)
      op = OP_PROG;
    else if (req.page_unlock_copy)
      op = OP_UNPROT;
    else if (req.discard)
      op = OP_DISC;
    else
      op = OP_NONE;
  end

endmodule : op_priority

`default_nettype wire

/* File: flash_block_user_port.sv */
`timescale 1ns/10ps
`default_nettype none

module flash_block_user_port #(
  parameter int SWAP_CYCLES = flash_port_pkg::SWAP_CYCLES_DEF
) (
  // Clock and resets
  input wire logic clk,
  input wire logic resetn,
  input wire logic block_reset_n,
  input wire logic sys_init,
  // Operation requests and modifiers
  input wire flash_port_pkg::req_s req,
  input wire flash_port_pkg::mode_s mode,
  input wire logic [flash_port_pkg::ADDR_W-1:0] addr,
  input wire logic [flash_port_pkg::WORD_BITS-1:0] write_word_in,
  input wire logic user_port_claim,
  // Answers
  output logic busy,
  output logic [1:0] status,
  output logic [flash_port_pkg::WORD_BITS-1:0] rd_data,
  output logic jtag_hold,
  // Nonvolatile array
  output flash_port_pkg::arr_req_s arr_req,
  input wire flash_port_pkg::arr_rsp_s arr_rsp
);
  import flash_port_pkg::*;

  if (SWAP_CYCLES < 1 || SWAP_CYCLES > 14)
  begin : g_bad_swap
    $error("SWAP_CYCLES must lie between 1 and 14");
  end

  localparam logic [3:0] SWAP_N = 4'(SWAP_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  typedef struct packed {
    state_e st;
    logic busy;
    logic [1:0] status;
    logic [WORD_BITS-1:0] rd;
    logic [WORD_BITS-1:0] rd_s;
    logic hold;
    logic bvalid;
    logic bmod;
    logic bwr;
    loc_s bloc;
    logic [BLKS-1:0][BLK_BITS-1:0] pbuf;
    logic [BLK_BITS-1:0] bb;
    logic [3:0] bb_idx;
    logic bb_ok;
    logic [3:0] cnt;
    op_e op;
    loc_s loc;
    logic [1:0] size;
    logic [WORD_BITS-1:0] wd;
    logic lock;
    logic pipe;
    logic [1:0] ecc;
    logic prot;
    arr_req_s arr;
  } core_s;

  localparam core_s RST = '{st: S_IDLE, op: OP_NONE, default: '0};

  core_s q;
  core_s n;
  op_e sel_op;

  op_priority u_prio (
    .sys_init(sys_init),
    .block_reset_n(block_reset_n),
    .req(req),
    .op(sel_op)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.
  function automatic logic [2:0] nbytes(input logic [1:0] sz);
    case (sz)
      SZ_BYTE: nbytes = 3'h1;
      SZ_HALF: nbytes = 3'h2;
      default: nbytes = 3'h4;
    endcase
  endfunction : nbytes

  function automatic loc_s decode(input logic [ADDR_W-1:0] a, input mode_s m);
    loc_s l;
    l.sector = a[SEC_HI:SEC_LO];
    l.spare = m.extra_page_select;
    // Forcing the page to zero lets one compare match any spare page access.
    l.page = m.extra_page_select ? '0 : a[PG_HI:PG_LO];
    if (m.side_block_select)
    begin
      l.blk = AUX_BLK;
      l.byte_off = {2'h0, a[AUX_BYTE_HI:0]};
    end
    else
    begin
      l.blk = {1'b0, a[BLK_HI:BLK_LO]};
      l.byte_off = a[BYTE_HI:0];
    end
    case (m.transfer_size)
      SZ_BYTE: l.byte_off = l.byte_off;
      SZ_HALF: l.byte_off[0] = 1'b0;
      default: l.byte_off[1:0] = 2'h0;
    endcase
    return l;
  endfunction : decode

  function automatic logic [BLK_BITS-1:0] merge(input logic [BLK_BITS-1:0] b,
      input logic [3:0] off, input logic [1:0] sz, input logic [WORD_BITS-1:0] w);
    logic [BLK_BITS-1:0] r;
    r = b;
    for (int i = 0; i < BUS_BYTES; i++)
    begin
      // Lines above the chosen size are never looked at, so stray data is harmless.
      if (i < int'(nbytes(sz)))
        r[(int'(off) + i) * BYTE_BITS +: BYTE_BITS] = w[i * BYTE_BITS +: BYTE_BITS];
    end
    return r;
  endfunction : merge

  function automatic logic [WORD_BITS-1:0] extract(input logic [BLK_BITS-1:0] b,
      input logic [3:0] off, input logic [1:0] sz);
    logic [WORD_BITS-1:0] r;
    r = '0;
    for (int i = 0; i < BUS_BYTES; i++)
    begin
      if (i < int'(nbytes(sz)))
        r[i * BYTE_BITS +: BYTE_BITS] = b[(int'(off) + i) * BYTE_BITS +: BYTE_BITS];
    end
    return r;
  endfunction : extract

  function automatic logic same_page(input core_s c, input loc_s l);
    return c.bvalid && c.bloc.sector == l.sector && c.bloc.page == l.page
      && c.bloc.spare == l.spare;
  endfunction : same_page

  function automatic logic dead_spare(input loc_s l);
    return l.spare && l.sector == SEC_ZERO;
  endfunction : dead_spare

  function automatic logic [1:0] worst(input logic [1:0] a, input logic [1:0] b);
    if (a == ST_MULTI || b == ST_MULTI)
      return ST_MULTI;
    else if (a == ST_FIX || b == ST_FIX)
      return ST_FIX;
    else
      return ST_OK;
  endfunction : worst

  function automatic arr_req_s arr_go(input arr_cmd_e c, input loc_s l,
      input logic [3:0] blk, input logic [BLK_BITS-1:0] wd, input logic lk);
    arr_req_s a;
    a.req = 1'b1;
    a.cmd = c;
    a.loc = l;
    a.loc.blk = blk;
    a.loc.byte_off = '0;
    a.wdata = wd;
    a.lock = lk;
    return a;
  endfunction : arr_go

  // Page and block buffers are kept equal, so merging from the page buffer
  // is the same as merging into the block buffer and copying it back.
  function automatic core_s put_word(input core_s c);
    logic [BLK_BITS-1:0] w;
    w = merge(c.pbuf[c.loc.blk], c.loc.byte_off, c.size, c.wd);
    c.bb = w;
    c.pbuf[c.loc.blk] = w;
    c.bb_idx = c.loc.blk;
    c.bb_ok = 1'b1;
    c.bmod = 1'b1;
    c.status = ST_OK;
    return c;
  endfunction : put_word

  function automatic core_s fin_read(input core_s c, input logic [WORD_BITS-1:0] w,
      input logic [1:0] s);
    if (c.pipe)
    begin
      // The code waits in ecc so that it moves with the data, as busy falls.
      c.rd_s = w;
      c.ecc = s;
      c.st = S_WAIT;
      c.busy = 1'b1;
    end
    else
    begin
      c.rd = w;
      c.status = s;
      c.st = S_IDLE;
      c.busy = 1'b0;
    end
    return c;
  endfunction : fin_read

  function automatic core_s start_load(input core_s c, input op_e o);
    c.st = S_LOAD;
    c.busy = 1'b1;
    c.cnt = '0;
    c.ecc = ST_OK;
    c.prot = 1'b0;
    c.op = o;
    c.arr = arr_go(ARR_RD, c.loc, '0, '0, 1'b0);
    return c;
  endfunction : start_load

  function automatic core_s finish(input core_s c, input logic [1:0] s);
    c.status = s;
    c.st = S_IDLE;
    c.busy = 1'b0;
    c.arr.req = 1'b0;
    return c;
  endfunction : finish

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb
  begin
    loc_s l;
    l = decode(addr, mode);
    n = q;
    n.hold = user_port_claim;
    case (q.st)
      S_IDLE:
      begin
        if (!q.busy && sel_op != OP_NONE)
        begin
          n.loc = l;
          n.size = mode.transfer_size;
          n.wd = write_word_in;
          n.lock = mode.lock_on_program;
          n.pipe = mode.pipe;
          n.op = sel_op;
          case (sel_op)
            OP_READ:
            begin
              if (dead_spare(l))
                n = fin_read(n, '0, ST_OK);
              else if (same_page(q, l))
                n = fin_read(n, extract(q.pbuf[l.blk], l.byte_off, n.size), ST_OK);
              else
              begin
                n.arr = arr_go(ARR_RD, l, l.blk, '0, 1'b0);
                n.st = S_READ;
                n.busy = 1'b1;
              end
            end
            OP_WRITE:
            begin
              // Every error branch leaves the buffers untouched.
              if (dead_spare(l))
                n.status = ST_FIX;
              else if (same_page(q, l))
              begin
                if (!q.bwr)
                  n.status = ST_FIX;
                else if (q.bb_ok && q.bb_idx == l.blk)
                  n = put_word(n);
                else
                begin
                  n.st = S_SWAP;
                  n.busy = 1'b1;
                  n.cnt = mode.pipe ? SWAP_N + PIPE_EXTRA : SWAP_N;
                end
              end
              else if (q.bvalid && q.bmod && mode.buffer_hold_guard)
                n.status = ST_LOSS;
              else
                n = start_load(n, OP_WRITE);
            end
            OP_UNPROT:
            begin
              if (!same_page(q, l) && q.bvalid && q.bmod && mode.buffer_hold_guard)
                n.status = ST_LOSS;
              else
                n = start_load(n, OP_UNPROT);
            end
            OP_PROG:
            begin
              if (dead_spare(l) || !same_page(q, l))
                n.status = ST_FIX;
              else if (!q.bmod)
                n.status = ST_FIX;
              else
              begin
                n.arr = arr_go(ARR_QUERY, l, '0, '0, 1'b0);
                n.st = S_QUERY;
                n.busy = 1'b1;
              end
            end
            OP_ERASE:
            begin
              if (!same_page(q, l) && q.bvalid && q.bmod && mode.buffer_hold_guard)
                n.status = ST_FIX;
              else
              begin
                n.arr = arr_go(ARR_QUERY, l, '0, '0, 1'b0);
                n.st = S_QUERY;
                n.busy = 1'b1;
              end
            end
            OP_DISC:
            begin
              n.bvalid = 1'b0;
              n.bmod = 1'b0;
              n.bb_ok = 1'b0;
              n.status = ST_OK;
            end
            default:
            begin
              n.op = q.op;
            end
          endcase
        end
      end
      S_SWAP:
      begin
        if (q.cnt == '0)
        begin
          n = put_word(n);
          n.busy = 1'b0;
          n.st = S_IDLE;
        end
        else
          n.cnt = q.cnt - 4'h1;
      end
      S_LOAD:
      begin
        if (arr_rsp.ack)
        begin
          n.pbuf[q.cnt] = arr_rsp.rdata;
          n.ecc = worst(q.ecc, arr_rsp.ecc);
          n.prot = q.prot | arr_rsp.prot;
          if (q.cnt == LAST_BLK)
          begin
            n.bvalid = 1'b1;
            n.bloc = q.loc;
            n.bmod = 1'b0;
            n.bb_ok = 1'b0;
            if (q.op == OP_UNPROT)
            begin
              n.bwr = 1'b1;
              n = finish(n, n.ecc);
            end
            else if (n.prot)
            begin
              n.bwr = 1'b0;
              n = finish(n, ST_FIX);
            end
            else
            begin
              n.bwr = 1'b1;
              n = put_word(n);
              n = finish(n, ST_OK);
            end
          end
          else
          begin
            n.cnt = q.cnt + 4'h1;
            n.arr.loc.blk = q.cnt + 4'h1;
          end
        end
      end
      S_QUERY:
      begin
        if (arr_rsp.ack)
        begin
          // The threshold answer is kept in ecc until the page is written or cleared.
          n.ecc = arr_rsp.thr ? ST_LOSS : ST_OK;
          if (arr_rsp.prot)
            n = finish(n, ST_FIX);
          else if (q.op == OP_PROG)
          begin
            n.st = S_PROG;
            n.cnt = '0;
            n.arr = arr_go(ARR_WR, q.loc, '0, q.pbuf[0], q.lock);
          end
          else
          begin
            n.st = S_ERASE;
            n.arr = arr_go(ARR_ERASE, q.loc, '0, '0, 1'b0);
          end
        end
      end
      S_PROG:
      begin
        if (arr_rsp.ack)
        begin
          if (q.cnt == LAST_BLK)
          begin
            n.bmod = 1'b0;
            n.bwr = !q.lock;
            n = finish(n, q.ecc);
          end
          else
          begin
            n.cnt = q.cnt + 4'h1;
            n.arr.loc.blk = q.cnt + 4'h1;
            n.arr.wdata = q.pbuf[q.cnt + 4'h1];
          end
        end
      end
      S_ERASE:
      begin
        if (arr_rsp.ack)
        begin
          // A cleared page must not be shadowed by stale buffer contents.
          if (same_page(q, q.loc))
          begin
            n.bvalid = 1'b0;
            n.bmod = 1'b0;
            n.bb_ok = 1'b0;
          end
          n = finish(n, q.ecc);
        end
      end
      S_READ:
      begin
        if (arr_rsp.ack)
        begin
          n.arr.req = 1'b0;
          n = fin_read(n, extract(arr_rsp.rdata, q.loc.byte_off, q.size), arr_rsp.ecc);
        end
      end
      S_WAIT:
      begin
        n.rd = q.rd_s;
        n.status = q.ecc;
        n.busy = 1'b0;
        n.st = S_IDLE;
      end
      default:
      begin
        n = RST;
      end
    endcase
    if (sel_op == OP_INIT || sel_op == OP_BRST)
    begin
      n = RST;
      n.hold = user_port_claim;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      q <= RST;
    else
      q <= n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register.
  assign busy = q.busy;
  assign status = q.status;
  assign rd_data = q.rd;
  assign jtag_hold = q.hold;
  assign arr_req = q.arr;

endmodule : flash_block_user_port

`default_nettype wire

/* File: flash_port_asserts.sv */
`timescale 1ns/10ps
`default_nettype none

module flash_port_asserts
  import flash_port_pkg::*;
(
  // Clock and resets
  input wire logic clk,
  input wire logic resetn,
  input wire logic block_reset_n,
  input wire logic sys_init,
  // Requests
  input wire flash_port_pkg::req_s req,
  input wire flash_port_pkg::mode_s mode,
  input wire logic [flash_port_pkg::ADDR_W-1:0] addr,
  input wire logic user_port_claim,
  // Answers and array link
  input wire logic busy,
  input wire logic [1:0] status,
  input wire logic [flash_port_pkg::WORD_BITS-1:0] rd_data,
  input wire logic jtag_hold,
  input wire flash_port_pkg::arr_req_s arr_req,
  input wire flash_port_pkg::arr_rsp_s arr_rsp
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic run;
  logic sec0;
  assign run = block_reset_n && !sys_init;
  assign sec0 = mode.extra_page_select && addr[SEC_HI:SEC_LO] == SEC_ZERO && run && !busy;

  a_claim_hold: assert property (
    $past(resetn) |-> jtag_hold == $past(user_port_claim)) else $error("claim not mirrored");
  a_busy_status: assert property (
    busy && $past(busy) |-> $stable(status)) else $error("status moved while busy");
  a_idle_hold: assert property (
    !busy && req == '0 && run |=> !busy && $stable(status) && $stable(rd_data))
    else $error("idle cycle changed outputs");
  a_arr_hold: assert property (
    arr_req.req && !arr_rsp.ack && run |=> arr_req.req && $stable(arr_req.loc))
    else $error("array request dropped early");
  a_arr_busy: assert property (
    arr_req.req |-> busy) else $error("array busy without busy");
  a_reset_clear: assert property (
    !block_reset_n || sys_init |=> !busy && status == ST_OK && !arr_req.req)
    else $error("block reset not applied");
  a_spare_write: assert property (
    sec0 && req.wr && !req.rd |=> !busy && status == ST_FIX) else $error("spare write ok");
  a_spare_read: assert property (
    sec0 && req.rd && !mode.pipe |=> rd_data == '0 && status == ST_OK)
    else $error("spare read not zero");

  c_busy_end: cover property (busy ##1 !busy);
  c_ecc_fix: cover property (arr_rsp.ack && arr_rsp.ecc == 2'h1);
  c_guard: cover property (status == ST_LOSS);
endmodule : flash_port_asserts

bind flash_block_user_port flash_port_asserts chk (
  .clk, .resetn, .block_reset_n, .sys_init, .req, .mode, .addr, .user_port_claim,
  .busy, .status, .rd_data, .jtag_hold, .arr_req, .arr_rsp
);

`default_nettype wire

/* File: nv_array_model.sv */
`timescale 1ns/10ps
`default_nettype none

module nv_array_model
  import flash_port_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Array link
  input wire flash_port_pkg::arr_req_s arr_req,
  output flash_port_pkg::arr_rsp_s arr_rsp,
  // Faults and pace chosen by the bench
  input wire logic [1:0] ecc_set,
  input wire logic prot_set,
  input wire logic [2:0] lag
);
  int waited;
  int wr_blocks;
  logic lock_seen;

  function automatic logic [7:0] byte_at(int s, int p, int b, int i);
    return 8'(s * 7 + p * 3 + b * 16 + i);
  endfunction : byte_at

  function automatic logic [127:0] block_at(loc_s l);
    logic [127:0] v;
    for (int i = 0; i < 16; i++)
      v[i*8 +: 8] = byte_at(l.sector, l.page, l.blk, i);
    return v;
  endfunction : block_at

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      arr_rsp <= '0;
      waited <= 0;
      wr_blocks <= 0;
      lock_seen <= 1'h0;
    end
    else if (arr_req.req && !arr_rsp.ack && waited >= int'(lag))
    begin
      // ECC and protect flags come from the bench and thr stays 0, so every fault is one a scenario asked for.
      arr_rsp <= '{1'h1, block_at(arr_req.loc), ecc_set, prot_set, 1'h0};
      waited <= 0;
      wr_blocks <= wr_blocks + int'(arr_req.cmd == ARR_WR);
      lock_seen <= arr_req.cmd == ARR_WR ? arr_req.lock : lock_seen;
    end
    else
    begin
      // A released data bus must not look like a fresh answer.
      arr_rsp.ack <= 1'h0;
      arr_rsp.rdata <= ~arr_rsp.rdata;
      waited <= arr_req.req ? waited + 1 : 0;
    end
  end
endmodule : nv_array_model

`default_nettype wire

/* File: tb.sv */
`timescale 1ns/10ps
`default_nettype none

module tb;
  import flash_port_pkg::*;
  localparam int SW = 3;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic block_reset_n = 1'h1;
  logic sys_init = 1'h0;
  req_s req = '0;
  mode_s mode = '0;
  mode_s md = '0;
  logic [17:0] addr = '0;
  logic [31:0] write_word_in = '0;
  logic user_port_claim = 1'h0;
  logic busy;
  logic jtag_hold;
  logic [1:0] status;
  logic [31:0] rd_data;
  arr_req_s arr_req;
  arr_rsp_s arr_rsp;
  logic [1:0] ecc_set = '0;
  logic prot_set = 1'h0;
  logic [2:0] lag = '0;
  int seed = 32'h9aa033d4;
  int mismatches = 0;
  int tests_run = 0;
  int nb;
  int o;
  int buf_pg = -1;
  logic [7:0] pb [144];

  always #25 clk = ~clk;

  flash_block_user_port #(.SWAP_CYCLES(SW)) dut (
    .clk, .resetn, .block_reset_n, .sys_init, .req, .mode, .addr, .write_word_in,
    .user_port_claim, .busy, .status, .rd_data, .jtag_hold, .arr_req, .arr_rsp
  );
  nv_array_model arr (.clk, .resetn, .arr_req, .arr_rsp, .ecc_set, .prot_set, .lag);

  ////////////////////////////////////////////////////////////
  function automatic int nby(logic [1:0] sz);
    return sz == SZ_BYTE ? 1 : sz == SZ_HALF ? 2 : 4;
  endfunction : nby

  function automatic logic [17:0] ad(int s, int p, int b, int f);
    return {6'(s), 5'(p), 3'(b), 4'(f)};
  endfunction : ad

  function automatic logic [31:0] expect_rd(int s, int p, int b, int f, logic [1:0] sz);
    logic [31:0] v;
    int n;
    v = '0;
    n = nby(sz);
    f = f - f % n;
    for (int i = 0; i < n; i++)
      v[i*8 +: 8] = s * 32 + p == buf_pg ? pb[b * 16 + f + i] : arr.byte_at(s, p, b, f + i);
    return v;
  endfunction : expect_rd

  task automatic check(logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check

  // Requests go up on one edge and drop on the taking edge, so each is held one cycle.
  task automatic op(req_s r, logic [17:0] a, logic [31:0] wd);
    @(posedge clk);
    req <= r;
    mode <= md;
    addr <= a;
    write_word_in <= wd;
    user_port_claim <= 1'($random(seed));
    @(posedge clk);
    req <= '0;
    #1;
    check(jtag_hold, user_port_claim);
    nb = 0;
    while (busy === 1'h1 && nb < 999)
    begin
      @(posedge clk);
      #1;
      nb++;
    end
  endtask : op

  task automatic wr(int s, int p, int b, int f, logic [1:0] sz, logic [31:0] wd);
    int n;
    n = nby(sz);
    wd = wd & ((32'h1 << (8 * n)) - 1);
    md.transfer_size = sz;
    if (s * 32 + p != buf_pg)
    begin
      for (int i = 0; i < 144; i++)
        pb[i] = arr.byte_at(s, p, i / 16, i % 16);
      buf_pg = s * 32 + p;
    end
    for (int i = 0; i < n; i++)
      pb[b * 16 + f - f % n + i] = wd[i*8 +: 8];
    op(6'h10, ad(s, p, b, f), wd);
    check(status, ST_OK);
  endtask : wr

  task automatic rd(req_s r, int s, int p, int b, int f, logic [1:0] sz);
    md.transfer_size = sz;
    op(r, ad(s, p, b, f), $random(seed));
    check(rd_data, expect_rd(s, p, b, f, sz));
  endtask : rd

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk);
    resetn <= 1'h1;
    #1;
    check(status, ST_OK);
    check(busy, 1'h0);
    lag <= 3'h2;
    wr(5, 2, 1, 4, SZ_HALF, $random(seed));
    rd(6'h20, 5, 2, 7, 0, 2'h2);
    wr(5, 2, 1, 8, 2'h3, $random(seed));
    check(nb, 0);
    wr(5, 2, 3, 0, SZ_BYTE, $random(seed));
    check(nb, SW);
    md.pipe = 1'h1;
    wr(5, 2, 4, 0, SZ_BYTE, $random(seed));
    check(nb, SW + 1);
    $display("write timing test done");
    for (int i = 0; i < 4; i++)
    begin
      o = $random(seed) & 15;
      wr(5, 2, 6, o, 2'(i), $random(seed));
      md.pipe = 1'(i);
      rd(6'h20, 5, 2, 6, o, 2'(i));
    end
    md.side_block_select = 1'h1;
    wr(5, 2, 8, 1, SZ_HALF, $random(seed));
    rd(6'h20, 5, 2, 8, 0, 2'h2);
    md.side_block_select = 1'h0;
    md.pipe = 1'h0;
    rd(6'h30, 5, 2, 7, 0, 2'h2);
    md.buffer_hold_guard = 1'h1;
    op(6'h10, ad(6, 0, 0, 0), 32'h1);
    check(status, ST_LOSS);
    md.buffer_hold_guard = 1'h0;
    rd(6'h20, 5, 2, 6, 0, 2'h2);
    $display("size and guard test done");
    md.extra_page_select = 1'h1;
    op(6'h10, ad(0, 9, 0, 0), 32'h5A);
    check(status, ST_FIX);
    op(6'h20, ad(0, 9, 0, 0), 32'h0);
    check(rd_data, 32'h0);
    md.extra_page_select = 1'h0;
    md.lock_on_program = 1'h1;
    op(6'h04, ad(5, 2, 0, 0), 32'h0);
    check(status, ST_OK);
    check(arr.wr_blocks, 9);
    check(arr.lock_seen, 1'h1);
    md.lock_on_program = 1'h0;
    op(6'h10, ad(5, 2, 0, 0), 32'h1);
    check(status, ST_FIX);
    op(6'h02, ad(5, 2, 0, 0), 32'h0);
    check(status, ST_OK);
    buf_pg = -1;
    wr(5, 2, 0, 0, SZ_BYTE, $random(seed));
    md.buffer_hold_guard = 1'h1;
    op(6'h01, ad(5, 2, 0, 0), 32'h0);
    wr(12, 0, 0, 0, SZ_BYTE, $random(seed));
    md.buffer_hold_guard = 1'h0;
    $display("spare and program test done");
    ecc_set <= 2'h1;
    lag <= 3'h3;
    md.pipe = 1'h1;
    rd(6'h20, 9, 1, 2, 0, 2'h2);
    md.pipe = 1'h0;
    check(status, ST_FIX);
    ecc_set <= 2'h2;
    op(6'h20, ad(9, 1, 2, 0), 32'h0);
    check(status, ST_MULTI);
    ecc_set <= 2'h0;
    prot_set <= 1'h1;
    op(6'h10, ad(10, 3, 0, 0), 32'h7);
    check(status, ST_FIX);
    for (int i = 0; i < 2; i++)
    begin
      prot_set <= 1'(i);
      op(6'h08, ad(10, 3, 0, 0), 32'h0);
      check(status, i ? ST_FIX : ST_OK);
    end
    prot_set <= 1'h0;
    $display("array fault test done");
    lag <= 3'h7;
    // First pass uses the block reset, second the system initialisation.
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      req <= 6'h20;
      addr <= ad(11, i, 0, 0);
      @(posedge clk);
      req <= '0;
      @(posedge clk);
      block_reset_n <= 1'(i);
      sys_init <= 1'(i);
      @(posedge clk);
      block_reset_n <= 1'h1;
      sys_init <= 1'h0;
      #1;
      check(busy, 1'h0);
      check(status, ST_OK);
      check(arr_req.req, 1'h0);
    end
    $display("block reset test done");
    give_verdict();
  end

  // The full sequence needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule : tb

`default_nettype wire
